// ---- pkg/dtc_pkg.sv ----
// ****************************************************************
// Shared constants and types of the dual reload timer.
// ****************************************************************
package dtc_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DIV_W  = 16;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [2:0] OFS_TIMER_A  = 3'h0;
  localparam logic [2:0] OFS_TIMER_B  = 3'h1;
  localparam logic [2:0] OFS_CTRL_A   = 3'h2;
  localparam logic [2:0] OFS_CTRL_B   = 3'h3;
  localparam logic [2:0] OFS_INT_EN   = 3'h4;
  localparam logic [2:0] OFS_PRESET_A = 3'h5;
  localparam logic [2:0] OFS_PRESET_B = 3'h6;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int unsigned CTRL_A_SRC_LSB = 0;
  localparam int unsigned CTRL_B_SRC_LSB = 0;
  localparam int unsigned CTRL_B_MODE    = 3;
  localparam int unsigned INT_EN_A       = 0;
  localparam int unsigned INT_EN_B       = 1;

  // ****************************************************************
  // Reset values and count limits.
  // ****************************************************************
  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_PRESET = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] CLEAR_VAL  = 8'h00;
  localparam logic [1:0] RST_INT_EN = 2'h0;

  // ****************************************************************
  // Prescaler divide ratios.
  // ****************************************************************
  localparam logic [15:0] DIV_8     = 16'h0008;
  localparam logic [15:0] DIV_64    = 16'h0040;
  localparam logic [15:0] DIV_65536 = 16'hffff;
  localparam logic [15:0] DIV_RST   = 16'h0000;

  typedef enum logic [1:0] {
    DTC_A_CPU,
    DTC_A_DIV8,
    DTC_A_DIV64,
    DTC_A_OVF_B
  } dtc_src_a_e;

  typedef enum logic [2:0] {
    DTC_B_CPU,
    DTC_B_DIV64K,
    DTC_B_EXT,
    DTC_B_LOW,
    DTC_B_HIGH
  } dtc_src_b_e;

  typedef enum logic {
    DTC_MODE_TIMER,
    DTC_MODE_COUNTER
  } dtc_mode_e;

endpackage

// ---- pkg/dtc_tick_if.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Prescaler ticks and the synchronised external edge.
// ****************************************************************
interface dtc_tick_if;
  logic div8;
  logic div64;
  logic div64k;
  logic ext_rise;

  modport src (
    output div8,
    output div64,
    output div64k,
    output ext_rise
  );

  modport use_ticks (
    input div8,
    input div64,
    input div64k,
    input ext_rise
  );
endinterface

// ---- design/dtc_prescaler.sv ----
`timescale 1ns/100ps
module dtc_prescaler (
  input  wire logic  mclk,
  input  wire logic  srst,
  input  wire logic  ext_in,
  dtc_tick_if.src    tick
);

  typedef struct packed {
    logic [15:0] div;
    logic        sync1;
    logic        sync2;
    logic        last;
  } dtc_pre_s;

  dtc_pre_s st_q;
  dtc_pre_s st_d;

  // ****************************************************************
  // Free running divider and input synchroniser.
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    st_d.div   = st_q.div + 16'h0001;
    st_d.sync1 = ext_in;
    st_d.sync2 = st_q.sync1;
    st_d.last  = st_q.sync2;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Tick decode, one cycle each per period.
  // ****************************************************************
  assign tick.div8     = (st_q.div[2:0] == 3'(dtc_pkg::DIV_8 - 16'h0001));
  assign tick.div64    = (st_q.div[5:0] == 6'(dtc_pkg::DIV_64 - 16'h0001));
  assign tick.div64k   = (st_q.div == dtc_pkg::DIV_65536);
  assign tick.ext_rise = st_q.sync2 & ~st_q.last;

endmodule // dtc_prescaler

// ---- design/dtc_timer.sv ----
`timescale 1ns/100ps
module dtc_timer (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        external_count_input,
  output logic             irq_a,
  output logic             irq_b
);

  // ****************************************************************
  // State of the block.
  // ****************************************************************
  typedef struct packed {
    logic [7:0]             cnt_a;
    logic [7:0]             cnt_b;
    logic [7:0]             pre_a;
    logic [7:0]             pre_b;
    dtc_pkg::dtc_src_a_e    src_a;
    dtc_pkg::dtc_src_b_e    src_b;
    dtc_pkg::dtc_mode_e     mode_b;
    logic [1:0]             int_en;
    logic                   irq_a;
    logic                   irq_b;
    logic [7:0]             rdata;
  } dtc_state_s;

  dtc_state_s st_q;
  dtc_state_s st_d;

  dtc_tick_if tick ();

  logic       tick_a;
  logic       tick_b;
  logic       ovf_a;
  logic       ovf_b;
  logic       wr_a;
  logic       wr_b;
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_int_en;
  logic       clear_b;
  logic [7:0] rd_mux;

  // ****************************************************************
  // Prescaler and external input synchroniser.
  // ****************************************************************
  dtc_prescaler u_prescaler (
    .mclk   (mclk),
    .srst   (srst),
    .ext_in (external_count_input),
    .tick   (tick.src)
  );

  // ****************************************************************
  // Write decode.
  // ****************************************************************
  assign wr_a      = wr && (addr == dtc_pkg::OFS_TIMER_A);
  assign wr_b      = wr && (addr == dtc_pkg::OFS_TIMER_B);
  assign wr_ctrl_a = wr && (addr == dtc_pkg::OFS_CTRL_A);
  assign wr_ctrl_b = wr && (addr == dtc_pkg::OFS_CTRL_B);
  assign wr_int_en = wr && (addr == dtc_pkg::OFS_INT_EN);

  // A zero written in counter mode clears the live count.
  assign clear_b = wr_b
                && (st_q.mode_b == dtc_pkg::DTC_MODE_COUNTER)
                && (wdata == dtc_pkg::CLEAR_VAL);

  // ****************************************************************
  // Timer B clock selection.
  // ****************************************************************
  always_comb begin
    tick_b = 1'b0;
    if (st_q.mode_b == dtc_pkg::DTC_MODE_COUNTER) begin
      tick_b = tick.ext_rise;
    end else begin
      case (st_q.src_b)
        dtc_pkg::DTC_B_CPU: begin
          tick_b = 1'b1;
        end
        dtc_pkg::DTC_B_DIV64K: begin
          tick_b = tick.div64k;
        end
        dtc_pkg::DTC_B_EXT: begin
          tick_b = tick.ext_rise;
        end
        dtc_pkg::DTC_B_LOW: begin
          tick_b = 1'b0;
        end
        dtc_pkg::DTC_B_HIGH: begin
          tick_b = 1'b0;
        end
        default: begin
          tick_b = 1'b0;
        end
      endcase
    end
  end

  // Timer B overflows on a tick at its top count, unless a clearing write comes in the same cycle.
  assign ovf_b = tick_b && (st_q.cnt_b == dtc_pkg::COUNT_MAX) && !clear_b;

  // ****************************************************************
  // Timer A clock selection.
  // ****************************************************************
  always_comb begin
    tick_a = 1'b0;
    unique case (st_q.src_a)
      dtc_pkg::DTC_A_CPU: begin
        tick_a = 1'b1;
      end
      dtc_pkg::DTC_A_DIV8: begin
        tick_a = tick.div8;
      end
      dtc_pkg::DTC_A_DIV64: begin
        tick_a = tick.div64;
      end
      dtc_pkg::DTC_A_OVF_B: begin
        tick_a = ovf_b;
      end
    endcase
  end

  assign ovf_a = tick_a && (st_q.cnt_a == dtc_pkg::COUNT_MAX);

  // ****************************************************************
  // Read multiplexer.
  // ****************************************************************
  always_comb begin
    rd_mux = 8'h00;
    case (addr)
      dtc_pkg::OFS_TIMER_A: begin
        rd_mux = st_q.cnt_a;
      end
      dtc_pkg::OFS_TIMER_B: begin
        rd_mux = st_q.cnt_b;
      end
      dtc_pkg::OFS_CTRL_A: begin
        rd_mux = {6'h00, st_q.src_a};
      end
      dtc_pkg::OFS_CTRL_B: begin
        rd_mux = {4'h0, st_q.mode_b, st_q.src_b};
      end
      dtc_pkg::OFS_INT_EN: begin
        rd_mux = {6'h00, st_q.int_en};
      end
      dtc_pkg::OFS_PRESET_A: begin
        rd_mux = st_q.pre_a;
      end
      dtc_pkg::OFS_PRESET_B: begin
        rd_mux = st_q.pre_b;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    st_d = st_q;

    // Control registers.
    if (wr_ctrl_a) begin
      st_d.src_a = dtc_pkg::dtc_src_a_e'(wdata[dtc_pkg::CTRL_A_SRC_LSB +: 2]);
    end
    if (wr_ctrl_b) begin
      st_d.src_b  = dtc_pkg::dtc_src_b_e'(wdata[dtc_pkg::CTRL_B_SRC_LSB +: 3]);
      st_d.mode_b = dtc_pkg::dtc_mode_e'(wdata[dtc_pkg::CTRL_B_MODE]);
    end
    if (wr_int_en) begin
      st_d.int_en = {wdata[dtc_pkg::INT_EN_B], wdata[dtc_pkg::INT_EN_A]};
    end

    // Presets.
    if (wr_a) begin
      st_d.pre_a = wdata;
    end
    if (wr_b) begin
      st_d.pre_b = wdata;
    end

    // Timer A counting.
    if (ovf_a) begin
      st_d.cnt_a = wr_a ? wdata : st_q.pre_a;
    end else if (tick_a) begin
      st_d.cnt_a = st_q.cnt_a + 8'h01;
    end

    // Timer B counting.
    if (clear_b) begin
      st_d.cnt_b = dtc_pkg::CLEAR_VAL;
    end else if (ovf_b) begin
      st_d.cnt_b = wr_b ? wdata : st_q.pre_b;
    end else if (tick_b) begin
      st_d.cnt_b = st_q.cnt_b + 8'h01;
    end

    // Interrupt requests stand in the cycle that shows the reloaded count.
    st_d.irq_a = ovf_a && st_q.int_en[dtc_pkg::INT_EN_A];
    st_d.irq_b = ovf_b && st_q.int_en[dtc_pkg::INT_EN_B];

    // Read data stand only in the cycle after the read strobe.
    st_d.rdata = rd ? rd_mux : 8'h00;
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q.cnt_a  <= dtc_pkg::RST_COUNT;
      st_q.cnt_b  <= dtc_pkg::RST_COUNT;
      st_q.pre_a  <= dtc_pkg::RST_PRESET;
      st_q.pre_b  <= dtc_pkg::RST_PRESET;
      st_q.src_a  <= dtc_pkg::DTC_A_CPU;
      st_q.src_b  <= dtc_pkg::DTC_B_CPU;
      st_q.mode_b <= dtc_pkg::DTC_MODE_TIMER;
      st_q.int_en <= dtc_pkg::RST_INT_EN;
      st_q.irq_a  <= 1'b0;
      st_q.irq_b  <= 1'b0;
      st_q.rdata  <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign rdata = st_q.rdata;
  assign irq_a = st_q.irq_a;
  assign irq_b = st_q.irq_b;

endmodule // dtc_timer

// ---- verif/dtc_timer_sva.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Port checks of the dual reload timer.
// ****************************************************************
module dtc_timer_sva (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       external_count_input,
  input wire logic       irq_a,
  input wire logic       irq_b
);
  logic [1:0] en_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge mclk) begin
    if (srst)
      en_q <= 2'h0;
    else if (wr && addr == 3'h4)
      en_q <= wdata[1:0];
  end
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_src_a_bits: assert property (rd && addr == 3'h2 |=> rdata[7:2] == 6'h00)
    else $error("timer a control has stray bits");
  a_src_b_bits: assert property (rd && addr == 3'h3 |=> rdata[7:4] == 4'h0)
    else $error("timer b control has stray bits");
  a_preset_a_echo: assert property (wr && addr == 3'h0 ##1 rd && addr == 3'h5 |=> rdata == $past(wdata, 2))
    else $error("preset a not stored");
  a_preset_b_echo: assert property (wr && addr == 3'h1 ##1 rd && addr == 3'h6 |=> rdata == $past(wdata, 2))
    else $error("preset b not stored");
  a_enable_echo: assert property (wr && addr == 3'h4 ##1 rd && addr == 3'h4 |=> rdata == {6'h00, $past(wdata[1:0], 2)})
    else $error("interrupt enable not stored");
  a_irq_a_gated: assert property (irq_a |-> $past(en_q[0]))
    else $error("timer a interrupt while disabled");
  a_irq_b_gated: assert property (irq_b |-> $past(en_q[1]))
    else $error("timer b interrupt while disabled");
  c_irq_a: cover property (irq_a);
  c_irq_b: cover property (irq_b);
  c_unmapped: cover property (rd && addr == 3'h7);
endmodule // dtc_timer_sva

// ---- verif/dtc_ext_source.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Source of external count edges, idle low.
// ****************************************************************
module dtc_ext_source (
  input wire logic mclk,
  output logic     ext_out
);
  initial ext_out = 1'b0;
  // Each level is held at least one cycle so every edge is seen.
  task automatic send(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge mclk);
      ext_out <= 1'b1;
      repeat (hi) @(posedge mclk);
      ext_out <= 1'b0;
      repeat (lo - 1) @(posedge mclk);
    end
  endtask
endmodule // dtc_ext_source

// ---- verif/dtc_timer_bench.sv ----
`timescale 1ns/100ps
module dtc_timer_bench;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic        ext;
  logic        irq_a;
  logic        irq_b;
  int          fails = 0;
  int          checks = 0;
  int          na = 0;
  int          nb = 0;
  int unsigned rs = 77545;
  int          tk = 0;
  always #10 mclk = ~mclk;
  // The prescaler runs free from reset; tk follows the cycles since reset.
  always @(posedge mclk) begin
    na <= na + int'(irq_a === 1'b1);
    nb <= nb + int'(irq_b === 1'b1);
    tk <= srst ? 0 : tk + 1;
  end
  dtc_timer i_dtc_timer (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .external_count_input(ext), .irq_a(irq_a), .irq_b(irq_b));
  dtc_ext_source i_dtc_ext_source (.mclk(mclk), .ext_out(ext));
  function automatic int unsigned rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic int adv(int c, int p, int k);
    repeat (k) c = (c == 255) ? p : c + 1;
    return c;
  endfunction
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
  endtask
  task automatic rel();
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrt(input logic [2:0] a, input logic [7:0] d);
    cyc(1'b1, a, d);
    rel();
  endtask
  task automatic rdv(input logic [2:0] a);
    cyc(1'b0, a, 8'h00);
    rel();
    #1;
    rv = rdata;
  endtask
  task automatic wr_rd(input logic [2:0] aw, input logic [7:0] d, input logic [2:0] ar);
    cyc(1'b1, aw, d);
    cyc(1'b0, ar, 8'h00);
    rel();
    #1;
    rv = rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rdv(a);
    chk(rv, e);
  endtask
  task automatic rst_vals();
    for (int a = 2; a < 8; a++) rdc(3'(a), 8'h00);
    $display("reset values done");
  endtask
  initial begin
    int b0;
    int n;
    int mb;
    logic [7:0] p;
    logic [7:0] a0;
    static logic [7:0] pa [3] = '{8'hf0, 8'hf0, 8'hfe};
    static int dv [3] = '{1, 8, 64};
    static logic [7:0] sb [4] = '{8'h03, 8'h04, 8'h07, 8'h02};
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rst_vals();
    p = 8'(rnd());
    wr_rd(dtc_pkg::OFS_TIMER_A, p, dtc_pkg::OFS_PRESET_A);
    chk(rv, p);
    wr_rd(dtc_pkg::OFS_TIMER_B, ~p, dtc_pkg::OFS_PRESET_B);
    chk(rv, ~p);
    wr_rd(dtc_pkg::OFS_INT_EN, 8'h03, dtc_pkg::OFS_INT_EN);
    chk(rv, 8'h03);
    wrt(dtc_pkg::OFS_TIMER_B, 8'hf0);
    repeat (300) @(posedge mclk);
    b0 = nb;
    repeat (160) @(posedge mclk);
    chk(8'(nb - b0), 8'h0a);
    wrt(dtc_pkg::OFS_INT_EN, 8'h01);
    repeat (2) @(posedge mclk);
    b0 = nb;
    repeat (160) @(posedge mclk);
    chk(8'(nb - b0), 8'h00);
    $display("timer b reload done");
    for (int i = 0; i < 3; i++) begin
      wrt(dtc_pkg::OFS_CTRL_A, 8'(i));
      wrt(dtc_pkg::OFS_TIMER_A, pa[i]);
      repeat (256 * dv[i] + 20) @(posedge mclk);
      b0 = na;
      repeat (10 * (256 - pa[i]) * dv[i]) @(posedge mclk);
      chk(8'(na - b0), 8'h0a);
    end
    $display("timer a sources done");
    wrt(dtc_pkg::OFS_INT_EN, 8'h03);
    wrt(dtc_pkg::OFS_CTRL_A, 8'h03);
    wrt(dtc_pkg::OFS_CTRL_B, 8'h08);
    wrt(dtc_pkg::OFS_TIMER_B, 8'h00);
    rdc(dtc_pkg::OFS_TIMER_B, 8'h00);
    wrt(dtc_pkg::OFS_TIMER_B, 8'hf0);
    rdv(dtc_pkg::OFS_TIMER_A);
    a0 = rv;
    n = 256 + int'(rnd() % 16);
    b0 = nb;
    i_dtc_ext_source.send(n, 1 + int'(rnd() % 3), 1 + int'(rnd() % 3));
    repeat (5) @(posedge mclk);
    mb = adv(0, 240, n);
    rdc(dtc_pkg::OFS_TIMER_B, 8'(mb));
    rdc(dtc_pkg::OFS_TIMER_B, 8'(mb));
    chk(8'(nb - b0), 8'h01);
    rdc(dtc_pkg::OFS_TIMER_A, (a0 == 8'hff) ? 8'hfe : a0 + 8'h01);
    $display("counter mode done");
    for (int i = 0; i < 4; i++) begin
      wrt(dtc_pkg::OFS_CTRL_B, sb[i]);
      n = 1 + int'(rnd() % 8);
      i_dtc_ext_source.send(n, 1, 2);
      repeat (5) @(posedge mclk);
      if (i == 3)
        mb = adv(mb, 240, n);
      rdc(dtc_pkg::OFS_TIMER_B, 8'(mb));
    end
    $display("timer b sources done");
    wrt(dtc_pkg::OFS_CTRL_B, 8'h01);
    rdv(dtc_pkg::OFS_TIMER_B);
    a0 = rv;
    repeat (65556 - (tk % 65536)) @(posedge mclk);
    rdc(dtc_pkg::OFS_TIMER_B, 8'(adv(int'(a0), 240, 1)));
    $display("slow source done");
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rst_vals();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    $display("Error %0t: timeout", $time);
    end_sim();
  end
endmodule // dtc_timer_bench
bind dtc_timer dtc_timer_sva i_dtc_timer_sva (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .external_count_input(external_count_input), .irq_a(irq_a), .irq_b(irq_b));
